/* src/btk_timekeeper.sv */
// BCD real-time clock and calendar counter with value windows
// Operation
// - Alarm minutes: tens bits 6-4, ones 3-0
// - Alarm seconds: tens bits 6-4, ones 3-0
// - Unused value register bits read zero
// - Run enable write needs unlock already set
// - Time and date value window writes ignored while locked; alarm window writes are not gated
// - Counter clock: crystal or internal, config bit
// - Internal oscillator routed to pin by pad field, only while it also clocks the counter
// - Day rollover clears time, increments day
// - After December 31 go to January 1
// - Weekday counts 0 to 6, no carry
// - Year wraps 99 to 00
// - BCD digit carries at ten
// - Month lengths 31 or 30, February special
// - February 29 days when year divisible four
// - Years 2000-2099, divisibility by four only
// - All fields second and coarser writable
// - Run enable counts, even during adjustment
// - Minute/second write resets both prescalers
// - Written values take effect same cycle
// - Half-second read-only, cleared by seconds write
// - Rollover pending flag low when access safe
// - High window access decrements pointer to zero
// - Unlock settable only right after key sequence
`timescale 1ns/1ps
module btk_timekeeper
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic secondary_crystal_oscillator_clk,
   input wire logic lfosc_clk,
   input wire logic config_word_three_low,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_q,
   output logic cal_pin_q,
   output logic second_pulse_q
);
   localparam int PAD_HI = btk_pkg::PAD_SEL_LO + 1;
   logic osc_prev_q, osc_lvl, osc_edge, half_q, half_tick, sec_tick;
   logic run_q, unlock_q, key_stage_q, armed_q;
   logic [13:0] presc_q;
   logic [1:0] ptr_q, aptr_q, pad_sel_q;
   logic [7:0] sec_q, min_q, hour_q, wday_q, day_q, month_q, year_q;
   logic [7:0] amin_q, asec_q, ahour_q, awday_q, aday_q, amonth_q;
   logic [7:0] sec_n, min_n, hour_n, day_n, month_n, year_n;
   logic sec_w, min_w, hour_w, day_w, month_w, year_w;
   logic [7:0] day_last;
   logic leap;
   logic wr_cfg, wr_valh, wr_vall, wr_key, acc_valh, minute_second_pair_wr;
   logic sync_flag;

   // Clock source select, edge of the chosen oscillator
   assign osc_lvl = config_word_three_low ? lfosc_clk : secondary_crystal_oscillator_clk;
   assign osc_edge = osc_lvl & ~osc_prev_q;
   assign half_tick = run_q && osc_edge && (presc_q == btk_pkg::PRESC_LAST);
   assign sec_tick = half_tick && half_q;
   assign wr_cfg = wr_en && (addr == btk_pkg::REG_CFG);
   assign wr_key = wr_en && (addr == btk_pkg::REG_KEY);
   assign wr_valh = wr_en && (addr == btk_pkg::REG_VALH) && unlock_q;
   assign wr_vall = wr_en && (addr == btk_pkg::REG_VALL) && unlock_q;
   assign acc_valh = (wr_en || rd_en) && (addr == btk_pkg::REG_VALH);
   assign minute_second_pair_wr = (wr_valh || wr_vall) && (ptr_q == btk_pkg::PTR_MINUTE_SECOND_PAIR);

   // Year in 2000-2099: BCD divisibility by four
   always_comb
   begin
      leap = year_q[4] ? (year_q[3:0] == 4'h2 || year_q[3:0] == 4'h6)
                       : (year_q[3:0] == 4'h0 || year_q[3:0] == 4'h4
                          || year_q[3:0] == 4'h8);
      case (month_q)
         8'h04, 8'h06, 8'h09, 8'h11: day_last = btk_pkg::DAYS_30;
         btk_pkg::MONTH_FEB: day_last = leap ? btk_pkg::DAYS_29 : btk_pkg::DAYS_28;
         default: day_last = btk_pkg::DAYS_31;
      endcase
   end

   // Field increments; carries at ten
   btk_bcd_step u_sec (.val(sec_q), .lo(btk_pkg::BCD_ZERO), .hi(btk_pkg::SEC_LAST),
      .nxt(sec_n), .wrap(sec_w));
   btk_bcd_step u_min (.val(min_q), .lo(btk_pkg::BCD_ZERO), .hi(btk_pkg::SEC_LAST),
      .nxt(min_n), .wrap(min_w));
   btk_bcd_step u_hour (.val(hour_q), .lo(btk_pkg::BCD_ZERO), .hi(btk_pkg::HOUR_LAST),
      .nxt(hour_n), .wrap(hour_w));
   btk_bcd_step u_day (.val(day_q), .lo(btk_pkg::BCD_ONE), .hi(day_last),
      .nxt(day_n), .wrap(day_w));
   btk_bcd_step u_month (.val(month_q), .lo(btk_pkg::BCD_ONE), .hi(btk_pkg::MONTH_LAST),
      .nxt(month_n), .wrap(month_w));
   btk_bcd_step u_year (.val(year_q), .lo(btk_pkg::BCD_ZERO), .hi(btk_pkg::YEAR_LAST),
      .nxt(year_n), .wrap(year_w));

   // Oscillator edge detect and prescalers
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         osc_prev_q <= 1'b0;
         presc_q <= '0;
         half_q <= 1'b0;
      end
      else
      begin
         osc_prev_q <= osc_lvl;
         if (minute_second_pair_wr)
            presc_q <= '0;
         else if (run_q && osc_edge)
            presc_q <= presc_q + 14'h0001;
         if (minute_second_pair_wr)
            half_q <= 1'b0;
         else if (half_tick)
            half_q <= ~half_q;
      end
   end

   // Unlock key sequence; armed for a single cycle only
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         key_stage_q <= 1'b0;
         armed_q <= 1'b0;
      end
      else
      begin
         armed_q <= wr_key && key_stage_q && (wdata == btk_pkg::KEY_SECOND);
         if (wr_key)
            key_stage_q <= (wdata == btk_pkg::KEY_FIRST);
      end
   end

   // Configuration register
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         run_q <= 1'b0;
         unlock_q <= 1'b0;
         ptr_q <= btk_pkg::PTR_MINUTE_SECOND_PAIR;
         aptr_q <= btk_pkg::PTR_MINUTE_SECOND_PAIR;
         pad_sel_q <= 2'h0;
      end
      else
      begin
         if (wr_cfg)
         begin
            ptr_q <= wdata[1:0];
            if (unlock_q)
               run_q <= wdata[btk_pkg::CFG_RUN_BIT];
            if (!wdata[btk_pkg::CFG_UNLOCK_BIT])
               unlock_q <= 1'b0;
            else if (armed_q)
               unlock_q <= 1'b1;
         end
         else if (acc_valh && ptr_q != btk_pkg::PTR_MINUTE_SECOND_PAIR)
            ptr_q <= ptr_q - 2'h1;
         if (wr_en && addr == btk_pkg::REG_ALRM_CFG)
            aptr_q <= wdata[1:0];
         else if ((wr_en || rd_en) && addr == btk_pkg::REG_ALRM_VALH
                  && aptr_q != btk_pkg::PTR_MINUTE_SECOND_PAIR)
            aptr_q <= aptr_q - 2'h1;
         if (wr_en && addr == btk_pkg::REG_PAD)
            pad_sel_q <= wdata[PAD_HI:btk_pkg::PAD_SEL_LO];
      end
   end

   // Time of day; write wins over same-cycle tick
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         sec_q <= btk_pkg::RST_TIME;
         min_q <= btk_pkg::RST_TIME;
         hour_q <= btk_pkg::RST_TIME;
         wday_q <= btk_pkg::RST_TIME;
      end
      else
      begin
         if (sec_tick)
         begin
            sec_q <= sec_n;
            if (sec_w)
            begin
               min_q <= min_n;
               if (min_w)
               begin
                  hour_q <= hour_n;
                  if (hour_w)
                     wday_q <= (wday_q >= btk_pkg::WDAY_LAST) ? btk_pkg::BCD_ZERO
                               : wday_q + 8'h01;
               end
            end
         end
         if (wr_vall && ptr_q == btk_pkg::PTR_MINUTE_SECOND_PAIR)
            sec_q <= wdata & btk_pkg::MASK_MINUTE_SECOND_PAIR;
         if (wr_valh && ptr_q == btk_pkg::PTR_MINUTE_SECOND_PAIR)
            min_q <= wdata & btk_pkg::MASK_MINUTE_SECOND_PAIR;
         if (wr_vall && ptr_q == btk_pkg::PTR_WDHR)
            hour_q <= wdata & btk_pkg::MASK_HOUR;
         if (wr_valh && ptr_q == btk_pkg::PTR_WDHR)
            wday_q <= wdata & btk_pkg::MASK_WDAY;
      end
   end

   // Calendar date
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         day_q <= btk_pkg::RST_DATE;
         month_q <= btk_pkg::RST_DATE;
         year_q <= btk_pkg::RST_TIME;
      end
      else
      begin
         if (sec_tick && sec_w && min_w && hour_w)
         begin
            day_q <= day_n;
            if (day_w)
            begin
               month_q <= month_n;
               if (month_w)
                  year_q <= year_n;
            end
         end
         if (wr_vall && ptr_q == btk_pkg::PTR_MTHDAY)
            day_q <= wdata & btk_pkg::MASK_DAY;
         if (wr_valh && ptr_q == btk_pkg::PTR_MTHDAY)
            month_q <= wdata & btk_pkg::MASK_MONTH;
         if (wr_vall && ptr_q == btk_pkg::PTR_YEAR)
            year_q <= wdata & btk_pkg::MASK_YEAR;
      end
   end

   // Alarm values; matching not built here
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         amin_q <= btk_pkg::RST_TIME;
         asec_q <= btk_pkg::RST_TIME;
         ahour_q <= btk_pkg::RST_TIME;
         awday_q <= btk_pkg::RST_TIME;
         aday_q <= btk_pkg::RST_DATE;
         amonth_q <= btk_pkg::RST_DATE;
      end
      else if (wr_en && addr == btk_pkg::REG_ALRM_VALH)
         case (aptr_q)
            btk_pkg::PTR_MINUTE_SECOND_PAIR: amin_q <= wdata & btk_pkg::MASK_MINUTE_SECOND_PAIR;
            btk_pkg::PTR_WDHR: awday_q <= wdata & btk_pkg::MASK_WDAY;
            btk_pkg::PTR_MTHDAY: amonth_q <= wdata & btk_pkg::MASK_MONTH;
            default: amin_q <= amin_q;
         endcase
      else if (wr_en && addr == btk_pkg::REG_ALRM_VALL)
         case (aptr_q)
            btk_pkg::PTR_MINUTE_SECOND_PAIR: asec_q <= wdata & btk_pkg::MASK_MINUTE_SECOND_PAIR;
            btk_pkg::PTR_WDHR: ahour_q <= wdata & btk_pkg::MASK_HOUR;
            btk_pkg::PTR_MTHDAY: aday_q <= wdata & btk_pkg::MASK_DAY;
            default: asec_q <= asec_q;
         endcase
   end

   // Pending flag raised shortly before a second tick; software polls it
   assign sync_flag = run_q && half_q && (presc_q >= btk_pkg::PRESC_LAST - btk_pkg::SYNC_LEAD);

   // Read port and pins, all registered
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         rdata_q <= 8'h00;
         cal_pin_q <= 1'b0;
         second_pulse_q <= 1'b0;
      end
      else
      begin
         second_pulse_q <= sec_tick;
         // Only the internal source may be driven out
         cal_pin_q <= config_word_three_low && (pad_sel_q == btk_pkg::PAD_SEL_OSC)
                      && lfosc_clk;
         if (rd_en)
            case (addr)
               btk_pkg::REG_CFG: rdata_q <= {run_q, 1'b0, unlock_q, sync_flag, 2'h0,
                                             ptr_q};
               btk_pkg::REG_VALH:
                  case (ptr_q)
                     btk_pkg::PTR_MINUTE_SECOND_PAIR: rdata_q <= min_q;
                     btk_pkg::PTR_WDHR: rdata_q <= wday_q;
                     btk_pkg::PTR_MTHDAY: rdata_q <= month_q;
                     default: rdata_q <= 8'h00;
                  endcase
               btk_pkg::REG_VALL:
                  case (ptr_q)
                     btk_pkg::PTR_MINUTE_SECOND_PAIR: rdata_q <= sec_q;
                     btk_pkg::PTR_WDHR: rdata_q <= hour_q;
                     btk_pkg::PTR_MTHDAY: rdata_q <= day_q;
                     default: rdata_q <= year_q;
                  endcase
               btk_pkg::REG_ALRM_CFG: rdata_q <= {6'h00, aptr_q};
               btk_pkg::REG_ALRM_VALH:
                  case (aptr_q)
                     btk_pkg::PTR_MINUTE_SECOND_PAIR: rdata_q <= amin_q;
                     btk_pkg::PTR_WDHR: rdata_q <= awday_q;
                     btk_pkg::PTR_MTHDAY: rdata_q <= amonth_q;
                     default: rdata_q <= 8'h00;
                  endcase
               btk_pkg::REG_ALRM_VALL:
                  case (aptr_q)
                     btk_pkg::PTR_MINUTE_SECOND_PAIR: rdata_q <= asec_q;
                     btk_pkg::PTR_WDHR: rdata_q <= ahour_q;
                     btk_pkg::PTR_MTHDAY: rdata_q <= aday_q;
                     default: rdata_q <= 8'h00;
                  endcase
               // Half-second visible here, never writable
               btk_pkg::REG_PAD: rdata_q <= {4'h0, half_q, pad_sel_q, 1'b0};
               default: rdata_q <= 8'h00;
            endcase
      end
   end

   run_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_cfg && !unlock_q |=> run_q == $past(run_q))
      else $error("run enable changed while locked");
   win_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_en && addr == btk_pkg::REG_VALL && ptr_q == btk_pkg::PTR_MINUTE_SECOND_PAIR && !unlock_q
      && !sec_tick |=> sec_q == $past(sec_q))
      else $error("locked window write took effect");
   ptr_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
      acc_valh && !wr_cfg && ptr_q != 2'h0 |=> ptr_q == $past(ptr_q) - 2'h1)
      else $error("pointer did not decrement");
   ptr_floor_a: assert property (@(posedge mclk) disable iff (!reset_n)
      acc_valh && ptr_q == 2'h0 |=> ptr_q == 2'h0)
      else $error("pointer left zero");
   presc_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
      minute_second_pair_wr |=> presc_q == 14'h0000 && !half_q)
      else $error("prescaler not cleared");
   unlock_key_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_cfg && !armed_q && !unlock_q |=> !unlock_q)
      else $error("unlock set without key");
   sec_wrap_a: assert property (@(posedge mclk) disable iff (!reset_n)
      sec_tick && sec_q == 8'h59 && !minute_second_pair_wr |=> sec_q == 8'h00)
      else $error("seconds did not wrap");
   day_roll_a: assert property (@(posedge mclk) disable iff (!reset_n)
      sec_tick && sec_q == 8'h59 && min_q == 8'h59 && hour_q == 8'h23 && !wr_en
      |=> hour_q == 8'h00 && day_q != $past(day_q))
      else $error("day rollover wrong");
   year_end_a: assert property (@(posedge mclk) disable iff (!reset_n)
      sec_tick && sec_w && min_w && hour_w && day_q == 8'h31 && month_q == 8'h12 && !wr_en
      |=> day_q == 8'h01 && month_q == 8'h01)
      else $error("year end rollover wrong");
   feb_leap_a: assert property (@(posedge mclk) disable iff (!reset_n)
      month_q == 8'h02 && year_q == 8'h24 |-> day_last == 8'h29)
      else $error("leap February wrong");
   blank_bit_a: assert property (@(posedge mclk) disable iff (!reset_n)
      rd_en && addr == btk_pkg::REG_ALRM_VALH && aptr_q == 2'h0 |=> !rdata_q[7])
      else $error("unused bit read one");
   tick_cov: cover property (@(posedge mclk) disable iff (!reset_n) sec_tick);
   unlock_cov: cover property (@(posedge mclk) disable iff (!reset_n) armed_q ##1 unlock_q);
   day_cov: cover property (@(posedge mclk) disable iff (!reset_n)
      sec_tick && hour_w && min_w && sec_w);
endmodule : btk_timekeeper

/* shared/btk_pkg.sv */
// Constants for the BCD calendar timekeeper
package btk_pkg;
   // Register selects on the special-function port
   localparam logic [2:0] REG_CFG = 3'h0;
   localparam logic [2:0] REG_VALH = 3'h1;
   localparam logic [2:0] REG_VALL = 3'h2;
   localparam logic [2:0] REG_ALRM_CFG = 3'h3;
   localparam logic [2:0] REG_ALRM_VALH = 3'h4;
   localparam logic [2:0] REG_ALRM_VALL = 3'h5;
   localparam logic [2:0] REG_PAD = 3'h6;
   localparam logic [2:0] REG_KEY = 3'h7;
   // Configuration and pad register fields
   localparam int CFG_RUN_BIT = 7;
   localparam int CFG_UNLOCK_BIT = 5;
   localparam int CFG_SYNC_BIT = 4;
   localparam int PAD_SEL_LO = 1;
   localparam logic [1:0] PAD_SEL_OSC = 2'h2;
   // Window pointer values
   localparam logic [1:0] PTR_MINUTE_SECOND_PAIR = 2'h0;
   localparam logic [1:0] PTR_WDHR = 2'h1;
   localparam logic [1:0] PTR_MTHDAY = 2'h2;
   localparam logic [1:0] PTR_YEAR = 2'h3;
   // Field masks, unused bits read zero
   localparam logic [7:0] MASK_MINUTE_SECOND_PAIR = 8'h7F;
   localparam logic [7:0] MASK_HOUR = 8'h3F;
   localparam logic [7:0] MASK_DAY = 8'h3F;
   localparam logic [7:0] MASK_MONTH = 8'h1F;
   localparam logic [7:0] MASK_WDAY = 8'h07;
   localparam logic [7:0] MASK_YEAR = 8'hFF;
   // BCD limits
   localparam logic [7:0] BCD_ZERO = 8'h00;
   localparam logic [7:0] BCD_ONE = 8'h01;
   localparam logic [7:0] SEC_LAST = 8'h59;
   localparam logic [7:0] HOUR_LAST = 8'h23;
   localparam logic [7:0] MONTH_LAST = 8'h12;
   localparam logic [7:0] YEAR_LAST = 8'h99;
   localparam logic [7:0] WDAY_LAST = 8'h06;
   localparam logic [7:0] DAYS_31 = 8'h31;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] MONTH_FEB = 8'h02;
   // Unlock key sequence
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   // Prescaler: 32768 oscillator edges per second
   localparam logic [13:0] PRESC_LAST = 14'h3FFF;
   localparam logic [13:0] SYNC_LEAD = 14'h0020;
   // Reset values
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_TIME = 8'h00;
endpackage : btk_pkg

/* src/btk_bcd_step.sv */
// One BCD field increment with wrap
`timescale 1ns/1ps
module btk_bcd_step
(
   input wire logic [7:0] val,
   input wire logic [7:0] lo,
   input wire logic [7:0] hi,
   output logic [7:0] nxt,
   output logic wrap
);
   always_comb
   begin
      wrap = 1'b0;
      if (val >= hi)
      begin
         nxt = lo;
         wrap = 1'b1;
      end
      else if (val[3:0] >= 4'h9)
      begin
         nxt = {val[7:4] + 4'h1, 4'h0};
      end
      else
      begin
         nxt = {val[7:4], val[3:0] + 4'h1};
      end
   end
endmodule : btk_bcd_step

/* verification/tb_btk_timekeeper.sv */
// Self-checking bench for the BCD calendar timekeeper
`timescale 1ns/1ps
module tb_btk_timekeeper;
   localparam int CYC_LIMIT = 80000;
   logic mclk;
   logic reset_n;
   logic secondary_crystal_oscillator_clk = 1'b0;
   logic lfosc_clk = 1'b0;
   logic config_word_three_low;
   logic wr_en;
   logic rd_en;
   logic [2:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata_q;
   logic cal_pin_q;
   logic second_pulse_q;
   logic [2:0] lf_div_q = 3'h0;
   logic seen_hi;
   logic seen_lo;
   logic early;
   int err_count;
   int tests_run;
   int cyc = 0;
   int t0;

   btk_timekeeper dut
   (
      .mclk(mclk),
      .reset_n(reset_n),
      .secondary_crystal_oscillator_clk(secondary_crystal_oscillator_clk),
      .lfosc_clk(lfosc_clk),
      .config_word_three_low(config_word_three_low),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .addr(addr),
      .wdata(wdata),
      .rdata_q(rdata_q),
      .cal_pin_q(cal_pin_q),
      .second_pulse_q(second_pulse_q)
   );

   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Crystal at the fastest rate mclk can sample; internal oscillator slower
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      secondary_crystal_oscillator_clk <= ~secondary_crystal_oscillator_clk;
      lf_div_q <= lf_div_q + 3'h1;
      lfosc_clk <= lf_div_q[2];
      if (cyc == CYC_LIMIT)
      begin
         err_count++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error at %0t: seen %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : chk

   // Strobe stays up into the next call, so back-to-back writes never double-assign
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      rd_en <= 1'b0;
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
   endtask : wr

   task automatic idle();
      @(posedge mclk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : idle

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge mclk);
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      chk(rdata_q, exp);
   endtask : rd_chk

   task automatic observe();
      seen_hi = 1'b0;
      seen_lo = 1'b0;
      repeat (16)
      begin
         @(posedge mclk);
         #1;
         seen_hi = seen_hi | (cal_pin_q === 1'b1);
         seen_lo = seen_lo | (cal_pin_q === 1'b0);
      end
   endtask : observe

   initial
   begin
      reset_n = 1'b0;
      config_word_three_low = 1'b0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      err_count = 0;
      tests_run = 0;
      early = 1'b0;
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      rd_chk(btk_pkg::REG_CFG, 8'h00);
      wr(btk_pkg::REG_VALL, 8'h33);
      rd_chk(btk_pkg::REG_VALL, 8'h00);
      wr(btk_pkg::REG_CFG, 8'h80);
      rd_chk(btk_pkg::REG_CFG, 8'h00);
      // An idle gap between key sequence and unlock write must leave the lock closed
      wr(btk_pkg::REG_KEY, btk_pkg::KEY_FIRST);
      wr(btk_pkg::REG_KEY, btk_pkg::KEY_SECOND);
      idle();
      wr(btk_pkg::REG_CFG, 8'h20);
      rd_chk(btk_pkg::REG_CFG, 8'h00);
      wr(btk_pkg::REG_KEY, btk_pkg::KEY_FIRST);
      wr(btk_pkg::REG_KEY, btk_pkg::KEY_SECOND);
      wr(btk_pkg::REG_CFG, 8'h20);
      rd_chk(btk_pkg::REG_CFG, 8'h20);
      // Last second of 2099, Saturday; pointer walks down from 3
      wr(btk_pkg::REG_CFG, 8'h23);
      wr(btk_pkg::REG_VALL, 8'h99);
      wr(btk_pkg::REG_VALH, 8'h00);
      wr(btk_pkg::REG_VALL, 8'h31);
      wr(btk_pkg::REG_VALH, 8'h12);
      wr(btk_pkg::REG_VALL, 8'h23);
      wr(btk_pkg::REG_VALH, 8'h06);
      wr(btk_pkg::REG_VALL, 8'h59);
      wr(btk_pkg::REG_VALH, 8'h59);
      rd_chk(btk_pkg::REG_VALL, 8'h59);
      rd_chk(btk_pkg::REG_VALH, 8'h59);
      wr(btk_pkg::REG_CFG, 8'h22);
      rd_chk(btk_pkg::REG_VALH, 8'h12);
      rd_chk(btk_pkg::REG_CFG, 8'h21);
      wr(btk_pkg::REG_ALRM_CFG, 8'h00);
      wr(btk_pkg::REG_ALRM_VALH, 8'h45);
      rd_chk(btk_pkg::REG_ALRM_VALH, 8'h45);
      wr(btk_pkg::REG_ALRM_VALH, 8'hFF);
      rd_chk(btk_pkg::REG_ALRM_VALH, 8'h7F);
      wr(btk_pkg::REG_ALRM_VALL, 8'hD9);
      rd_chk(btk_pkg::REG_ALRM_VALL, 8'h59);
      // Run a while first, so a missed prescaler clear shows as an early tick
      wr(btk_pkg::REG_CFG, 8'hA0);
      idle();
      repeat (2000) @(posedge mclk);
      wr(btk_pkg::REG_VALL, 8'h59);
      t0 = cyc;
      rd_chk(btk_pkg::REG_CFG, 8'hA0);
      while (cyc - t0 < 40000)
      begin
         @(posedge mclk);
         #1;
         early = early | (second_pulse_q === 1'b1) | (cal_pin_q === 1'b1);
      end
      chk({7'h00, early}, 8'h00);
      rd_chk(btk_pkg::REG_PAD, 8'h08);
      while (second_pulse_q !== 1'b1)
      begin
         @(posedge mclk);
         #1;
      end
      chk({7'h00, (cyc - t0 > 64000) && (cyc - t0 < 67000)}, 8'h01);
      @(posedge mclk);
      #1;
      chk({7'h00, second_pulse_q}, 8'h00);
      // One tick must have rippled through every field
      wr(btk_pkg::REG_CFG, 8'hA3);
      rd_chk(btk_pkg::REG_VALL, 8'h00);
      rd_chk(btk_pkg::REG_VALH, 8'h00);
      rd_chk(btk_pkg::REG_VALL, 8'h01);
      rd_chk(btk_pkg::REG_VALH, 8'h01);
      rd_chk(btk_pkg::REG_VALL, 8'h00);
      rd_chk(btk_pkg::REG_VALH, 8'h00);
      rd_chk(btk_pkg::REG_VALL, 8'h00);
      rd_chk(btk_pkg::REG_VALH, 8'h00);
      // Pin routing only while the internal oscillator is selected
      wr(btk_pkg::REG_PAD, 8'h04);
      idle();
      observe();
      chk({7'h00, seen_hi}, 8'h00);
      @(posedge mclk);
      config_word_three_low <= 1'b1;
      repeat (2) @(posedge mclk);
      observe();
      chk({6'h00, seen_hi, seen_lo}, 8'h03);
      // Leap February, held until the end so the month length check sees it
      wr(btk_pkg::REG_CFG, 8'hA3);
      wr(btk_pkg::REG_VALL, 8'h24);
      wr(btk_pkg::REG_VALH, 8'h00);
      wr(btk_pkg::REG_VALH, 8'h02);
      rd_chk(btk_pkg::REG_CFG, 8'hA1);
      give_verdict();
   end
endmodule : tb_btk_timekeeper
